// ==== pkg/fspc_map.svh ====
// Constants for the flash self-programming controller: offsets, fields,
// reset values and timing counts. Assumes a 200 MHz core clock.
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH

// Register map (byte addresses on the AXI4-Lite bus)
`define FSPC_AXI_AW 8
`define FSPC_CTRL_OFS 8'h00
`define FSPC_CTRL_RESET 8'h00

// Control register fields
`define FSPC_BIT_IRQEN 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_RSVD 5
`define FSPC_BIT_REEN 4
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_WRITE 2
`define FSPC_BIT_ERASE 1
`define FSPC_BIT_ARM 0

// Command patterns in the lower five control bits
`define FSPC_PAT_LOAD 5'h01
`define FSPC_PAT_ERASE 5'h03
`define FSPC_PAT_WRITE 5'h05
`define FSPC_PAT_LOCK 5'h09
`define FSPC_PAT_REEN 5'h11

// Arm window length in clock cycles
`define FSPC_ARM_CYCLES 3'h4

// Pointer layout: word-in-page field and page-number field
`define FSPC_WORD_LSB 1
`define FSPC_WORD_MSB 6
`define FSPC_PAGE_LSB 7
`define FSPC_PAGE_MSB 15
`define FSPC_PAGE_WORDS 64
`define FSPC_STALLING_SECTION_FIRST_PAGE 9'h070

// Lock data field in the low data byte
`define FSPC_LOCK_LSB 2
`define FSPC_LOCK_MSB 5
`define FSPC_LOCK_RESET 4'hF

// Programming time, counted in core clock cycles
`define FSPC_CLK_PERIOD_NS 5
`define FSPC_PROG_MIN_NS 3700000
`define FSPC_PROG_MAX_NS 4500000
`define FSPC_PROG_CYCLES \
  ((`FSPC_PROG_MIN_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)

// AXI responses
`define FSPC_RESP_OKAY 2'h0
`define FSPC_RESP_SLVERR 2'h2

`endif

// ==== pkg/fspc_pkg.sv ====
// Types for the flash self-programming controller.
// Constants live in fspc_map.svh.
package fspc_pkg;

  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_ARMED = 5'h02,
    ST_ERASE = 5'h04,
    ST_WRITE = 5'h08,
    ST_LOCK  = 5'h10
  } fspc_state_t;

  typedef enum logic [2:0]
  {
    CMD_NONE  = 3'h0,
    CMD_LOAD  = 3'h1,
    CMD_ERASE = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_LOCK  = 3'h4,
    CMD_REEN  = 3'h5
  } fspc_cmd_t;

endpackage

// ==== hw/fspc_page_buf.sv ====
// Temporary page buffer of the self-programming controller.
// Assumes one load per slot between clears; clear wins over load.
`timescale 1ns/1ps
`include "fspc_map.svh"

module fspc_page_buf
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic load,
  input wire logic [5:0] loadIdx,
  input wire logic [15:0] loadData,
  input wire logic [5:0] rdIdx,
  output logic [15:0] rdData
);
  typedef struct packed
  {
    logic [`FSPC_PAGE_WORDS-1:0][15:0] words;
    logic [15:0] rdData;
  } fspc_buf_t;

  fspc_buf_t s_q;
  fspc_buf_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (clr)
    begin
      // Cleared slots read as erased flash
      s_d.words = '1;
    end
    else if (load)
    begin
      s_d.words[loadIdx] = loadData;
    end
    s_d.rdData = s_q.words[rdIdx];
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
endmodule

// ==== hw/fspc_ctrl.sv ====
// Flash self-programming controller: control register on AXI4-Lite,
// store-program command sequencer, page buffer and read-section guard.
// Assumes the CPU pulses spmExec for one cycle per store-program
// instruction and presents its pointer and data registers alongside.
//
// Overview of operation
// - Erase+arm then store-program within four cycles erases pointer's page.
// - Erase-select clears at erase end or if four cycles pass idle.
// - Stall CPU for stalling-section targets; other section stays readable.
// - Arm bit enables store-program four cycles; select bits pick operation.
// - Arm alone: store-program loads data word into buffer slot.
// - Arm clears on completion or four idle cycles; held during erase/write.
// - Control writes with undefined low five bit patterns start no command.
// - Pointer bits 6:1 give the word field and bits 15:7 the page field.
// - Page address latched at operation start; pointer changes ignored.
// - Lock programming and re-enable ignore the pointer; load, erase and write use it.
// - Program-memory loads address bytes; pointer bit zero picks byte.
// - Write+arm then store-program programs buffer into pointer's page.
// - Buffer clears after page write, on re-enable, and on reset.
// - EEPROM write during page loading discards loaded buffer words.
// - Level interrupt while enabled and arm bit reads zero.
// - Read section blocked and busy flag set during erase or write.
// - Lock command programs lock bits whose data bits 5:2 are zero.
// - Lock programming never stalls the CPU nor blocks reading.
// - Busy flag also clears when a page load starts.
// - Register: enable 7, busy 6, zero 5, command bits 4 to 0.
// - Erase, write and lock take the programming time, 3.7 to 4.5 ms.
`timescale 1ns/1ps
`include "fspc_map.svh"

module fspc_ctrl
#(
  parameter int PROG_CYCLES = `FSPC_PROG_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [`FSPC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FSPC_AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU side
  input wire logic spmExec,
  input wire logic [15:0] ptrZ,
  input wire logic [15:0] dataR1R0,
  input wire logic lpmReq,
  input wire logic eepromWrite,
  output logic cpuStall,
  output logic spmIrq,
  output logic [7:0] lpmByte,
  // Flash array side
  output logic [15:1] flashRdWordAddr,
  input wire logic [15:0] flashRdData,
  output logic flashEraseStart,
  output logic flashWriteStart,
  output logic [8:0] flashPageAddr,
  output logic rwwReadBlock,
  output logic [3:0] lockBits,
  input wire logic [5:0] pgBufRdIdx,
  output logic [15:0] pgBufRdData
);
  import fspc_pkg::*;

  localparam logic [19:0] PROG_LAST = 20'(PROG_CYCLES - 1);

  typedef struct packed
  {
    fspc_state_t state;
    fspc_cmd_t cmd;
    logic irqEn;
    logic rwwBusy;
    logic [2:0] armCnt;
    logic [19:0] progCnt;
    logic [8:0] pageAddr;
    logic nrwwOp;
    logic [3:0] lockBits;
    logic [7:0] lpmByte;
    logic eraseStart;
    logic writeStart;
    logic awPend;
    logic [`FSPC_AXI_AW-1:0] awAddr;
    logic wPend;
    logic [7:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
  } fspc_ctrl_state_t;

  fspc_ctrl_state_t s_q;
  fspc_ctrl_state_t s_d;

  logic bufClr;
  logic bufLoad;

  // Only the five documented patterns start anything
  function automatic fspc_cmd_t decodeCmd(input logic [4:0] pat);
    fspc_cmd_t c;
    c = CMD_NONE;
    case (pat)
      `FSPC_PAT_LOAD: c = CMD_LOAD;
      `FSPC_PAT_ERASE: c = CMD_ERASE;
      `FSPC_PAT_WRITE: c = CMD_WRITE;
      `FSPC_PAT_LOCK: c = CMD_LOCK;
      `FSPC_PAT_REEN: c = CMD_REEN;
      default: c = CMD_NONE;
    endcase
    return c;
  endfunction

  // Select bits as the register shows them for a command
  function automatic logic [3:0] cmdBits(input fspc_cmd_t c);
    logic [3:0] b;
    b = 4'h0;
    case (c)
      CMD_ERASE: b = 4'h1;
      CMD_WRITE: b = 4'h2;
      CMD_LOCK: b = 4'h4;
      CMD_REEN: b = 4'h8;
      default: b = 4'h0;
    endcase
    return b;
  endfunction

  function automatic logic isCtrl(input logic [`FSPC_AXI_AW-1:0] a);
    return a[`FSPC_AXI_AW-1:2] == `FSPC_CTRL_OFS >> 2;
  endfunction

  function automatic logic [7:0] ctrlView(input fspc_ctrl_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`FSPC_BIT_IRQEN] = s.irqEn;
    v[`FSPC_BIT_BUSY] = s.rwwBusy;
    v[`FSPC_BIT_RSVD] = 1'b0;
    v[`FSPC_BIT_ARM] = s.state != ST_IDLE;
    v[4:1] = (s.state == ST_IDLE) ? 4'h0 : cmdBits(s.cmd);
    return v;
  endfunction

  always_comb
  begin
    logic doWrite;
    logic [8:0] ptrPage;
    doWrite = 1'b0;
    ptrPage = ptrZ[`FSPC_PAGE_MSB:`FSPC_PAGE_LSB];
    s_d = s_q;
    s_d.eraseStart = 1'b0;
    s_d.writeStart = 1'b0;
    bufClr = 1'b0;
    bufLoad = 1'b0;

    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.awPend = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.wPend = 1'b1;
      s_d.wData = s_axi_wdata[7:0];
      s_d.wLane0 = s_axi_wstrb[0];
    end
    if (s_q.awPend && s_q.wPend)
    begin
      s_d.awPend = 1'b0;
      s_d.wPend = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = isCtrl(s_q.awAddr) ? `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
      doWrite = isCtrl(s_q.awAddr) && s_q.wLane0;
    end
    if (s_q.bValid && s_axi_bready)
    begin
      s_d.bValid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rValid = 1'b1;
      s_d.rData = isCtrl(s_axi_araddr) ? ctrlView(s_q) : 8'h00;
      s_d.rResp = isCtrl(s_axi_araddr) ? `FSPC_RESP_OKAY
                                       : `FSPC_RESP_SLVERR;
    end
    else if (s_q.rValid && s_axi_rready)
    begin
      s_d.rValid = 1'b0;
    end

    if (doWrite)
    begin
      s_d.irqEn = s_q.wData[`FSPC_BIT_IRQEN];
    end

    // Byte-wide program-memory read; bit zero picks the half
    if (lpmReq)
    begin
      s_d.lpmByte = ptrZ[0] ? flashRdData[15:8] : flashRdData[7:0];
    end

    // A discarded load must not lose to a same-cycle store
    if (eepromWrite)
    begin
      bufClr = 1'b1;
    end

    case (s_q.state)
      ST_IDLE:
      begin
        if (doWrite && decodeCmd(s_q.wData[4:0]) != CMD_NONE)
        begin
          s_d.state = ST_ARMED;
          s_d.cmd = decodeCmd(s_q.wData[4:0]);
          s_d.armCnt = `FSPC_ARM_CYCLES;
        end
      end
      ST_ARMED:
      begin
        if (spmExec)
        begin
          s_d.state = ST_IDLE;
          case (s_q.cmd)
            CMD_LOAD:
            begin
              bufLoad = !eepromWrite;
              s_d.rwwBusy = 1'b0;
            end
            CMD_ERASE:
            begin
              s_d.state = ST_ERASE;
              s_d.pageAddr = ptrPage;
              s_d.nrwwOp = ptrPage >= `FSPC_STALLING_SECTION_FIRST_PAGE;
              s_d.rwwBusy = 1'b1;
              s_d.eraseStart = 1'b1;
              s_d.progCnt = 20'h00000;
            end
            CMD_WRITE:
            begin
              s_d.state = ST_WRITE;
              s_d.pageAddr = ptrPage;
              s_d.nrwwOp = ptrPage >= `FSPC_STALLING_SECTION_FIRST_PAGE;
              s_d.rwwBusy = 1'b1;
              s_d.writeStart = 1'b1;
              s_d.progCnt = 20'h00000;
            end
            CMD_LOCK:
            begin
              // Pointer not looked at; zero data bits program locks
              s_d.state = ST_LOCK;
              s_d.lockBits = s_q.lockBits &
                dataR1R0[`FSPC_LOCK_MSB:`FSPC_LOCK_LSB];
              s_d.progCnt = 20'h00000;
            end
            CMD_REEN:
            begin
              s_d.rwwBusy = 1'b0;
              bufClr = 1'b1;
            end
            default:
            begin
              s_d.state = ST_IDLE;
            end
          endcase
        end
        else if (s_q.armCnt == 3'h1)
        begin
          // Window lapsed: arm and select bits drop together
          s_d.state = ST_IDLE;
          s_d.cmd = CMD_NONE;
        end
        else
        begin
          s_d.armCnt = s_q.armCnt - 3'h1;
        end
      end
      ST_ERASE, ST_WRITE, ST_LOCK:
      begin
        // Arm stays up; control writes to command bits ignored here
        if (s_q.progCnt == PROG_LAST)
        begin
          s_d.state = ST_IDLE;
          s_d.cmd = CMD_NONE;
          if (s_q.state == ST_WRITE)
          begin
            bufClr = 1'b1;
          end
        end
        else
        begin
          s_d.progCnt = s_q.progCnt + 20'h00001;
        end
      end
      default:
      begin
        s_d.state = ST_IDLE;
        s_d.cmd = CMD_NONE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q.state <= ST_IDLE;
      s_q.cmd <= CMD_NONE;
      s_q.irqEn <= 1'b0;
      s_q.rwwBusy <= 1'b0;
      s_q.armCnt <= 3'h0;
      s_q.progCnt <= 20'h00000;
      s_q.pageAddr <= 9'h000;
      s_q.nrwwOp <= 1'b0;
      s_q.lockBits <= `FSPC_LOCK_RESET;
      s_q.lpmByte <= 8'h00;
      s_q.eraseStart <= 1'b0;
      s_q.writeStart <= 1'b0;
      s_q.awPend <= 1'b0;
      s_q.awAddr <= '0;
      s_q.wPend <= 1'b0;
      s_q.wData <= 8'h00;
      s_q.wLane0 <= 1'b0;
      s_q.bValid <= 1'b0;
      s_q.bResp <= 2'h0;
      s_q.rValid <= 1'b0;
      s_q.rData <= 8'h00;
      s_q.rResp <= 2'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  fspc_page_buf u_buf
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .clr(bufClr),
    .load(bufLoad),
    .loadIdx(ptrZ[`FSPC_WORD_MSB:`FSPC_WORD_LSB]),
    .loadData(dataR1R0),
    .rdIdx(pgBufRdIdx),
    .rdData(pgBufRdData)
  );

  // One write and one read in flight; a held response blocks new ones
  assign s_axi_awready = !s_q.awPend && !s_q.bValid;
  assign s_axi_wready = !s_q.wPend && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = {24'h000000, s_q.rData};
  assign s_axi_rresp = s_q.rResp;

  // Lock programming never stalls nor blocks
  assign cpuStall = s_q.nrwwOp &&
    (s_q.state == ST_ERASE || s_q.state == ST_WRITE);
  assign rwwReadBlock = s_q.rwwBusy;
  assign spmIrq = s_q.irqEn && s_q.state == ST_IDLE;
  assign lpmByte = s_q.lpmByte;
  assign flashRdWordAddr = ptrZ[15:1];
  assign flashEraseStart = s_q.eraseStart;
  assign flashWriteStart = s_q.writeStart;
  assign flashPageAddr = s_q.pageAddr;
  assign lockBits = s_q.lockBits;
endmodule

// ==== sim/fspc_cpu_model.sv ====
// Behavioural CPU core that issues store-program instructions.
// Assumes go pulses for one cycle with ptr, data and dly valid beside it.
`timescale 1ns/1ps

module fspc_cpu_model
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [1:0] dly,
  input wire logic [15:0] ptr,
  input wire logic [15:0] data,
  input wire logic cpuStall,
  output logic spmExec,
  output logic [15:0] ptrZ,
  output logic [15:0] dataR1R0
);
  logic pend;
  logic [1:0] cnt;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      spmExec <= 1'h0;
      pend <= 1'h0;
      cnt <= 2'h0;
      ptrZ <= 16'h0;
      dataR1R0 <= 16'h0;
    end
    else
    begin
      spmExec <= 1'h0;
      if (go)
      begin
        ptrZ <= ptr;
        dataR1R0 <= data;
        spmExec <= (dly == 2'h0);
        pend <= (dly != 2'h0);
        cnt <= dly - 2'h1;
      end
      // A halted core issues nothing
      else if (pend && !cpuStall)
      begin
        if (cnt == 2'h0)
        begin
          spmExec <= 1'h1;
          pend <= 1'h0;
        end
        else
          cnt <= cnt - 2'h1;
      end
      // Software reuses its registers once the instruction has issued
      if (spmExec)
      begin
        ptrZ <= ~ptrZ;
        dataR1R0 <= ~dataR1R0;
      end
    end
  end
endmodule

// ==== sim/fspc_ctrl_checker.sv ====
// Port-level assertions for the self-programming controller.
// Bound to fspc_ctrl; sees only its ports.
`timescale 1ns/1ps

module fspc_ctrl_checker
#(
  parameter int PROG_CYCLES = 8
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] ptrZ,
  input wire logic lpmReq,
  input wire logic cpuStall,
  input wire logic spmIrq,
  input wire logic [7:0] lpmByte,
  input wire logic [15:1] flashRdWordAddr,
  input wire logic [15:0] flashRdData,
  input wire logic flashEraseStart,
  input wire logic flashWriteStart,
  input wire logic [8:0] flashPageAddr,
  input wire logic rwwReadBlock,
  input wire logic [3:0] lockBits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] lpmExp_q;
  int stallCnt_q;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lpmExp_q <= 8'h0;
      stallCnt_q <= 0;
    end
    else
    begin
      lpmExp_q <= ptrZ[0] ? flashRdData[15:8] : flashRdData[7:0];
      stallCnt_q <= cpuStall ? stallCnt_q + 1 : 0;
    end
  end
  a_stall_page: assert property (cpuStall |-> flashPageAddr >= 9'h070)
    else $error("stall on a concurrent-read page");
  a_start_busy: assert property ((flashEraseStart || flashWriteStart)
    |-> ##[0:1] rwwReadBlock) else $error("busy flag not set");
  a_page_hold: assert property ((flashEraseStart || flashWriteStart)
    |=> $stable(flashPageAddr)[*8]) else $error("page moved mid-op");
  a_lock_mono: assert property ((lockBits & ~$past(lockBits)) == 4'h0)
    else $error("lock bit returned to one");
  a_stall_min: assert property ($rose(cpuStall) |-> cpuStall[*8])
    else $error("stall too short");
  a_stall_max: assert property (stallCnt_q <= PROG_CYCLES + 2)
    else $error("stall too long");
  a_irq_op: assert property ((cpuStall || flashEraseStart) |-> !spmIrq)
    else $error("irq during operation");
  a_lpm_byte: assert property (lpmReq |=> lpmByte == lpmExp_q)
    else $error("wrong program byte");
  a_rd_addr: assert property (flashRdWordAddr == ptrZ[15:1])
    else $error("read word address mismatch");
  c_erase: cover property (flashEraseStart);
  c_write: cover property (flashWriteStart);
  c_lpm: cover property (lpmReq);
endmodule

bind fspc_ctrl fspc_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_i
(
  .core_clk(core_clk), .rstn(rstn), .ptrZ(ptrZ), .lpmReq(lpmReq),
  .cpuStall(cpuStall), .spmIrq(spmIrq), .lpmByte(lpmByte),
  .flashRdWordAddr(flashRdWordAddr), .flashRdData(flashRdData),
  .flashEraseStart(flashEraseStart), .flashWriteStart(flashWriteStart),
  .flashPageAddr(flashPageAddr), .rwwReadBlock(rwwReadBlock),
  .lockBits(lockBits)
);

// ==== sim/fspc_ctrl_tb.sv ====
// Self-checking bench for the self-programming controller.
// Assumes fspc_cpu_model as the core and a 200 MHz clock.
`timescale 1ns/1ps
`include "fspc_map.svh"

module fspc_ctrl_tb;
  import fspc_pkg::*;
  typedef struct {logic [7:0] wd; logic [7:0] rb; logic irq;} fspc_row_t;
  fspc_row_t rows [7] = '{'{8'h80, 8'h80, 1'h1}, '{8'hFF, 8'h80, 1'h1},
    '{8'h47, 8'h00, 1'h0}, '{8'h9B, 8'h80, 1'h1}, '{8'h0D, 8'h00, 1'h0},
    '{8'h15, 8'h00, 1'h0}, '{8'h1E, 8'h00, 1'h0}};
  logic core_clk = 1'h0, rstn = 1'h0, go = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, lpmByte;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, lpmReq = '0, eepromWrite = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, spmExec, cpuStall, spmIrq, flashEraseStart;
  logic flashWriteStart, rwwReadBlock;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, dly = '0;
  logic [15:0] ptrZ, dataR1R0, pgBufRdData, ptr = '0, data = '0;
  logic [15:0] flashRdData = 16'hBEEF;
  logic [15:1] flashRdWordAddr;
  logic [8:0] flashPageAddr;
  logic [3:0] lockBits, ev;
  logic [5:0] pgBufRdIdx = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  int miscompares = 0, total_checks = 0;
  assign ev = {!cpuStall, spmIrq, flashWriteStart, flashEraseStart};
  always #2.5 core_clk = ~core_clk;

  fspc_ctrl #(.PROG_CYCLES(40)) dut
  (
    .core_clk, .rstn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spmExec,
    .ptrZ, .dataR1R0, .lpmReq, .eepromWrite, .cpuStall, .spmIrq, .lpmByte,
    .flashRdWordAddr, .flashRdData, .flashEraseStart, .flashWriteStart,
    .flashPageAddr, .rwwReadBlock, .lockBits, .pgBufRdIdx, .pgBufRdData
  );
  fspc_cpu_model cpu
  (
    .core_clk, .rstn, .go, .dly, .ptr, .data, .cpuStall, .spmExec, .ptrZ,
    .dataR1R0
  );

  task chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task rc(input logic [7:0] e);
    rd(`FSPC_CTRL_OFS);
    chk("ctrl", rdat, {24'h0, e});
  endtask
  task spm(input logic [7:0] c, input logic [15:0] p, d, input logic [1:0] w);
    wr(`FSPC_CTRL_OFS, c);
    go <= 1'h1;
    ptr <= p;
    data <= d;
    dly <= w;
    @(posedge core_clk);
    go <= 1'h0;
  endtask
  task wt(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ev[k] !== 1'h1 && n < 300);
    chk("event", ev[k], 1'h1);
  endtask
  task bf(input logic [5:0] i, input logic [15:0] e);
    pgBufRdIdx <= i;
    repeat (2) @(posedge core_clk);
    chk("buffer", pgBufRdData, e);
  endtask
  // The core reuses its pointer after the store, so the caller names the
  // byte that the pointer selected when the read was taken
  task lp(input logic [7:0] e);
    lpmReq <= 1'h1;
    @(posedge core_clk);
    lpmReq <= 1'h0;
    @(posedge core_clk);
    chk("lpm", lpmByte, e);
  endtask
  task results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    results();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'h1;
    rc(`FSPC_CTRL_RESET);
    chk("lock", lockBits, `FSPC_LOCK_RESET);
    bf(6'h05, 16'hFFFF);
    chk("irq", spmIrq, 1'h0);
    rd(8'h04);
    chk("rresp", resp, `FSPC_RESP_SLVERR);
    wr(8'h08, 8'h83);
    chk("bresp", resp, `FSPC_RESP_SLVERR);
    // Lane 0 masked: the control byte must stay untouched
    s_axi_wstrb <= 4'hE;
    wr(`FSPC_CTRL_OFS, 8'h80);
    s_axi_wstrb <= 4'hF;
    chk("bresp", resp, `FSPC_RESP_OKAY);
    rc(8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(`FSPC_CTRL_OFS, rows[i].wd);
      rc(rows[i].rb);
      chk("irq", spmIrq, rows[i].irq);
    end
    $display("test patterns done");
    // Instruction arrives after the arm window has closed
    spm(8'h01, 16'h0002, 16'h1234, 2'h3);
    // Let the late store land while idle, not in the next arm window
    repeat (4) @(posedge core_clk);
    spm(8'h03, 16'h0080, 16'h0, 2'h3);
    repeat (6) @(posedge core_clk);
    bf(6'h01, 16'hFFFF);
    chk("busy", rwwReadBlock, 1'h0);
    rc(8'h00);
    $display("test expiry done");
    spm(8'h81, 16'h0003, 16'hA5C3, 2'h0);
    lp(8'hBE);
    spm(8'h81, 16'h007E, 16'h1234, 2'h1);
    lp(8'hEF);
    bf(6'h01, 16'hA5C3);
    bf(6'h3F, 16'h1234);
    chk("irq", spmIrq, 1'h1);
    spm(8'h83, 16'h0080, 16'h0, 2'h1);
    wt(0);
    chk("page", flashPageAddr, 9'h001);
    chk("stall", cpuStall, 1'h0);
    rc(8'hC3);
    wr(`FSPC_CTRL_OFS, 8'h81);
    rc(8'hC3);
    wt(2);
    chk("page", flashPageAddr, 9'h001);
    rc(8'hC0);
    spm(8'h91, 16'h0, 16'h0, 2'h0);
    repeat (2) @(posedge core_clk);
    rc(8'h80);
    bf(6'h01, 16'hFFFF);
    $display("test erase done");
    spm(8'h81, 16'h0004, 16'h5A5A, 2'h0);
    spm(8'h85, 16'h0080, 16'hFFFF, 2'h0);
    wt(1);
    chk("page", flashPageAddr, 9'h001);
    wt(2);
    bf(6'h02, 16'hFFFF);
    rc(8'hC0);
    spm(8'h81, 16'h0000, 16'h1111, 2'h0);
    repeat (2) @(posedge core_clk);
    rc(8'h80);
    bf(6'h00, 16'h1111);
    eepromWrite <= 1'h1;
    @(posedge core_clk);
    eepromWrite <= 1'h0;
    bf(6'h00, 16'hFFFF);
    $display("test write done");
    spm(8'h83, 16'h3800, 16'h0, 2'h0);
    wt(0);
    chk("stall", cpuStall, 1'h1);
    chk("page", flashPageAddr, 9'h070);
    wt(3);
    rc(8'hC0);
    $display("test stall done");
    spm(8'h89, 16'hFFFF, 16'hFFD7, 2'h0);
    repeat (2) @(posedge core_clk);
    chk("lock", lockBits, 4'h5);
    chk("stall", cpuStall, 1'h0);
    wt(2);
    rc(8'hC0);
    $display("test lock done");
    results();
  end
endmodule
